// ### rtl/iwd_pkg.sv
// Constants shared by the isolated input module watchdog and port logic.
// Assumes a single 20 MHz module clock and a plain register port.
`default_nettype none

package iwd_pkg;

    // Module clock
    localparam int CLK_FREQ_MHZ = 20;

    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_WDT_STAT = 8'h04;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_MASK     = 8'h14;
    localparam logic [7:0] ADDR_PORT01   = 8'h18;
    localparam logic [7:0] ADDR_PORT23   = 8'h1C;
    localparam logic [7:0] ADDR_PORT0    = 8'h20;
    localparam logic [7:0] ADDR_PORT1    = 8'h24;
    localparam logic [7:0] ADDR_PORT2    = 8'h28;
    localparam logic [7:0] ADDR_PORT3    = 8'h2C;
    localparam logic [7:0] ADDR_DAV      = 8'h30;

    // Control register fields
    localparam int CTRL_WDT_EN  = 0;
    localparam int CTRL_CLK_EXT = 1;
    localparam int CTRL_SOFT_RST = 2;

    // Status / mask fields
    localparam int STAT_WDT    = 0;
    localparam int STAT_DAV_LO = 1;
    localparam int STAT_W      = 5;

    // Interrupt enable fields
    localparam int IEN_DAV_LO  = 0;
    localparam int IEN_EDGE_LO = 4;

    // Ports
    localparam int NUM_PORTS  = 4;
    localparam int PORT_W     = 16;
    localparam int NUM_CHAN   = NUM_PORTS * PORT_W;

    // Debounce setting in units of 100 ns; reset value is 18.0 us
    localparam logic [15:0] DEBOUNCE_RST = 16'h00B4;

    // Internal sample clock: 1 MHz
    localparam int SAMPLE_FREQ_MHZ = 1;
    localparam int SAMPLE_CYCLES   = CLK_FREQ_MHZ / SAMPLE_FREQ_MHZ;

    // Watchdog prescaler tick and timeouts
    localparam int WDT_TICK_US     = 1000;
    localparam int WDT_TICK_CYCLES = WDT_TICK_US * CLK_FREQ_MHZ;
    localparam int WDT_T_SHORT_MS  = 150;
    localparam int WDT_T_MID_MS    = 600;
    localparam int WDT_T_LONG_MS   = 1200;
    localparam int US_PER_MS       = 1000;
    localparam logic [15:0] WDT_TICKS_SHORT =
        16'(WDT_T_SHORT_MS * US_PER_MS / WDT_TICK_US);
    localparam logic [15:0] WDT_TICKS_MID =
        16'(WDT_T_MID_MS * US_PER_MS / WDT_TICK_US);
    localparam logic [15:0] WDT_TICKS_LONG =
        16'(WDT_T_LONG_MS * US_PER_MS / WDT_TICK_US);

    // Strap code {strap_b, strap_a}, 1 = jumper fitted
    localparam logic [1:0] STRAP_NONE = 2'h0;
    localparam logic [1:0] STRAP_A    = 2'h1;
    localparam logic [1:0] STRAP_B    = 2'h2;

endpackage : iwd_pkg

`default_nettype wire

// ### rtl/iwd_wdt_if.sv
// Signals between the register block and the watchdog counter.
// Assumes both ends run on the module clock.
`default_nettype none

interface iwd_wdt_if;
    logic        enable;
    logic        kick;
    logic [1:0]  strap;
    logic [15:0] count;
    logic        expired;

    modport ctl (output enable, output kick, output strap,
                 input count, input expired);
    modport wdt (input enable, input kick, input strap,
                 output count, output expired);
endinterface : iwd_wdt_if

`default_nettype wire

// ### rtl/iwd_watchdog.sv
// Watchdog counter with a millisecond prescaler and strap-selected limit.
// Assumes the strap code is already synchronised to the module clock.
`default_nettype none

module iwd_watchdog
    import iwd_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYCLES
)(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    iwd_wdt_if.wdt    wdt
);

    function automatic logic [15:0] limit_of(input logic [1:0] code);
        logic [15:0] lim;
        lim = WDT_TICKS_LONG;
        unique case (code)
            STRAP_NONE: lim = WDT_TICKS_MID;
            STRAP_A:    lim = WDT_TICKS_SHORT;
            STRAP_B:    lim = WDT_TICKS_LONG;
            default:    lim = WDT_TICKS_LONG;
        endcase
        return lim;
    endfunction : limit_of

    logic [15:0] pre_cnt;
    logic [15:0] tick_cnt;
    logic        en_d;

    wire         restart   = wdt.kick | (wdt.enable & ~en_d);
    wire         tick      = (pre_cnt == 16'(TICK_CYCLES - 1));
    wire  [15:0] limit     = limit_of(wdt.strap);
    wire         at_limit  = (tick_cnt >= limit);

    assign wdt.count   = tick_cnt;
    assign wdt.expired = wdt.enable & at_limit;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pre_cnt  <= 16'h0000;
            tick_cnt <= 16'h0000;
            en_d     <= 1'b0;
        end
        else
        begin
            en_d <= wdt.enable;
            if (restart || !wdt.enable)
            begin
                pre_cnt  <= 16'h0000;
                tick_cnt <= 16'h0000;
            end
            else if (tick)
            begin
                pre_cnt <= 16'h0000;
                if (!at_limit)
                    tick_cnt <= tick_cnt + 16'h0001;
            end
            else
                pre_cnt <= pre_cnt + 16'h0001;
        end
    end

endmodule : iwd_watchdog

`default_nettype wire

// ### rtl/iwd_top.sv
// Watchdog, port read-back, capture markers and interrupts of a 64-channel
// isolated input module. Assumes comparators outside deliver one logic
// level per channel, and a host on a plain strobe register port.
`default_nettype none

module iwd_top
    import iwd_pkg::*;
#(
    parameter int WDT_TICK_CYC = WDT_TICK_CYCLES
)(
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic [7:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata,
    input  wire logic                 i_timeout_strap_a,
    input  wire logic                 i_timeout_strap_b,
    input  wire logic [NUM_CHAN-1:0]  i_chan_level,
    input  wire logic                 i_port0_capture_trigger_n,
    input  wire logic                 i_port1_capture_trigger_n,
    input  wire logic                 i_port2_capture_trigger_n,
    input  wire logic                 i_port3_capture_trigger_n,
    output logic                      o_port0_data_avail_n,
    output logic                      o_port1_data_avail_n,
    output logic                      o_port2_data_avail_n,
    output logic                      o_port3_data_avail_n,
    output logic                      o_port0_event_irq_n,
    output logic                      o_port1_event_irq_n,
    output logic                      o_port2_event_irq_n,
    output logic                      o_port3_event_irq_n,
    output logic                      o_sysreset_n,
    output logic                      o_sysreset_oe,
    output logic                      o_irq
);

    // Pin synchronisers
    logic [NUM_CHAN-1:0]  chan_s1;
    logic [NUM_CHAN-1:0]  chan_s2;
    logic [1:0]           strap_s1;
    logic [1:0]           strap_s2;
    logic [NUM_PORTS-1:0] trig_s1;
    logic [NUM_PORTS-1:0] trig_s2;
    logic [NUM_PORTS-1:0] trig_d;

    // Registers
    logic                 wdt_en;
    logic                 clk_ext;
    logic [15:0]          debounce;
    logic [3:0]           dav_ien;
    logic [3:0]           edge_ien;
    logic [STAT_W-1:0]    status;
    logic [STAT_W-1:0]    mask;
    logic [NUM_PORTS-1:0] data_available_event;
    logic                 wdt_fired;
    logic [4:0]           samp_cnt;

    iwd_wdt_if wdt_bus ();

    iwd_watchdog #(
        .TICK_CYCLES (WDT_TICK_CYC)
    ) u_wdt (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .wdt       (wdt_bus.wdt)
    );

    // Port hit: its own word or the paired 32-bit word
    function automatic logic port_hit(input logic [7:0] a,
                                      input logic [7:0] single,
                                      input logic [7:0] pair);
        return (a == single) | (a == pair);
    endfunction : port_hit

    // Address decode
    wire wr_ctrl   = i_wr & (i_addr == ADDR_CTRL);
    wire wr_deb    = i_wr & (i_addr == ADDR_DEBOUNCE);
    wire wr_ien    = i_wr & (i_addr == ADDR_IRQ_EN);
    wire wr_status = i_wr & (i_addr == ADDR_STATUS);
    wire wr_mask   = i_wr & (i_addr == ADDR_MASK);
    wire rd_wdt    = i_rd & (i_addr == ADDR_WDT_STAT);
    wire soft_rst  = wr_ctrl & i_wdata[CTRL_SOFT_RST];

    // Reads of port data clear that port's marker
    wire [NUM_PORTS-1:0] rd_port;
    assign rd_port[0] = i_rd & port_hit(i_addr, ADDR_PORT0, ADDR_PORT01);
    assign rd_port[1] = i_rd & port_hit(i_addr, ADDR_PORT1, ADDR_PORT01);
    assign rd_port[2] = i_rd & port_hit(i_addr, ADDR_PORT2, ADDR_PORT23);
    assign rd_port[3] = i_rd & port_hit(i_addr, ADDR_PORT3, ADDR_PORT23);

    // Capture events
    wire [NUM_PORTS-1:0] trig_fall = trig_d & ~trig_s2;
    wire                 samp_tick = (samp_cnt == 5'(SAMPLE_CYCLES - 1));
    wire                 to_ext    = wr_ctrl & i_wdata[CTRL_CLK_EXT]
                                   & ~clk_ext;
    wire [NUM_PORTS-1:0] cap_ev    = clk_ext ? trig_fall
                                   : {NUM_PORTS{samp_tick}};
    wire [NUM_PORTS-1:0] dav_clr   = rd_port | {NUM_PORTS{to_ext}};
    wire [NUM_PORTS-1:0] cap_keep  = cap_ev & ~{NUM_PORTS{to_ext}};

    // Watchdog hookup
    assign wdt_bus.enable = wdt_en;
    assign wdt_bus.kick   = rd_wdt;
    assign wdt_bus.strap  = strap_s2;

    // Interrupt events
    wire wdt_rise = wdt_bus.expired & ~wdt_fired;
    // A set in the cycle of its clear wins
    wire [STAT_W-1:0] stat_set = {cap_keep, wdt_rise};
    wire [STAT_W-1:0] stat_clr = wr_status ? i_wdata[STAT_W-1:0]
                                           : {STAT_W{1'b0}};

    // Port words
    wire [PORT_W-1:0] port_word [NUM_PORTS];
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++)
        begin : g_port
            assign port_word[g] = chan_s2[g*PORT_W +: PORT_W];
        end
    endgenerate

    wire [NUM_PORTS-1:0] port_irq = data_available_event & dav_ien;

    // Read mux
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (i_addr)
            ADDR_CTRL:     next_rdata = {30'h0000_0000, clk_ext, wdt_en};
            ADDR_WDT_STAT: next_rdata = {wdt_bus.count, 12'h000,
                                         strap_s2, wdt_bus.expired, wdt_en};
            ADDR_DEBOUNCE: next_rdata = {16'h0000, debounce};
            ADDR_IRQ_EN:   next_rdata = {24'h00_0000, edge_ien, dav_ien};
            ADDR_STATUS:   next_rdata = {27'h000_0000, status};
            ADDR_MASK:     next_rdata = {27'h000_0000, mask};
            ADDR_PORT01:   next_rdata = {port_word[1], port_word[0]};
            ADDR_PORT23:   next_rdata = {port_word[3], port_word[2]};
            ADDR_PORT0:    next_rdata = {16'h0000, port_word[0]};
            ADDR_PORT1:    next_rdata = {16'h0000, port_word[1]};
            ADDR_PORT2:    next_rdata = {16'h0000, port_word[2]};
            ADDR_PORT3:    next_rdata = {16'h0000, port_word[3]};
            ADDR_DAV:      next_rdata = {28'h000_0000, data_available_event};
            default:       next_rdata = 32'h0000_0000;
        endcase
    end

    // Synchronisers
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            chan_s1  <= '0;
            chan_s2  <= '0;
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            trig_s1  <= 4'hF;
            trig_s2  <= 4'hF;
            trig_d   <= 4'hF;
        end
        else
        begin
            chan_s1  <= i_chan_level;
            chan_s2  <= chan_s1;
            strap_s1 <= {i_timeout_strap_b, i_timeout_strap_a};
            strap_s2 <= strap_s1;
            trig_s1  <= {i_port3_capture_trigger_n,
                         i_port2_capture_trigger_n,
                         i_port1_capture_trigger_n,
                         i_port0_capture_trigger_n};
            trig_s2  <= trig_s1;
            trig_d   <= trig_s2;
        end
    end

    // Configuration registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wdt_en   <= 1'b0;
            clk_ext  <= 1'b0;
            debounce <= DEBOUNCE_RST;
            dav_ien  <= 4'h0;
            edge_ien <= 4'h0;
            mask     <= '0;
        end
        else if (soft_rst)
        begin
            wdt_en   <= 1'b0;
            clk_ext  <= 1'b0;
            debounce <= DEBOUNCE_RST;
            dav_ien  <= 4'h0;
            edge_ien <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                wdt_en  <= i_wdata[CTRL_WDT_EN];
                clk_ext <= i_wdata[CTRL_CLK_EXT];
            end
            if (wr_deb)
                debounce <= i_wdata[15:0];
            if (wr_ien)
            begin
                dav_ien  <= i_wdata[IEN_DAV_LO +: NUM_PORTS];
                edge_ien <= i_wdata[IEN_EDGE_LO +: NUM_PORTS];
            end
            if (wr_mask)
                mask <= i_wdata[STAT_W-1:0];
        end
    end

    // Markers and sticky status
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            data_available_event       <= 4'h0;
            status    <= '0;
            wdt_fired <= 1'b0;
        end
        else
        begin
            // Capture that coincides with a read clear is kept; one in the cycle of the switch to external is dropped
            data_available_event       <= (data_available_event & ~dav_clr) | cap_keep;
            status    <= (status & ~stat_clr) | stat_set;
            wdt_fired <= wdt_bus.expired;
        end
    end

    // Sample clock divider, one pulse per microsecond
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            samp_cnt <= 5'h00;
        else
            samp_cnt <= samp_tick ? 5'h00 : samp_cnt + 5'h01;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 32'h0000_0000;
        else
            o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end

    // Outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sysreset_n         <= 1'b1;
            o_sysreset_oe        <= 1'b0;
            o_irq                <= 1'b0;
            o_port0_data_avail_n <= 1'b1;
            o_port1_data_avail_n <= 1'b1;
            o_port2_data_avail_n <= 1'b1;
            o_port3_data_avail_n <= 1'b1;
            o_port0_event_irq_n  <= 1'b1;
            o_port1_event_irq_n  <= 1'b1;
            o_port2_event_irq_n  <= 1'b1;
            o_port3_event_irq_n  <= 1'b1;
        end
        else
        begin
            o_sysreset_n         <= ~wdt_bus.expired;
            o_sysreset_oe        <= wdt_bus.expired;
            o_irq                <= |(status & mask);
            o_port0_data_avail_n <= ~data_available_event[0];
            o_port1_data_avail_n <= ~data_available_event[1];
            o_port2_data_avail_n <= ~data_available_event[2];
            o_port3_data_avail_n <= ~data_available_event[3];
            o_port0_event_irq_n  <= ~port_irq[0];
            o_port1_event_irq_n  <= ~port_irq[1];
            o_port2_event_irq_n  <= ~port_irq[2];
            o_port3_event_irq_n  <= ~port_irq[3];
        end
    end

endmodule : iwd_top

`default_nettype wire

// ### verification/iwd_props.sv
// Checker on the top-level ports of the watchdog and port block.
// Assumes straps stay still while the watchdog runs.
`default_nettype none

module iwd_props
    import iwd_pkg::*;
#(
    parameter int WDT_TICK_CYC = WDT_TICK_CYCLES
)(
    input wire logic                i_clk_sys,
    input wire logic                i_rst_n,
    input wire logic [7:0]          i_addr,
    input wire logic [31:0]         i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [31:0]         o_rdata,
    input wire logic                i_timeout_strap_a,
    input wire logic                i_timeout_strap_b,
    input wire logic [NUM_CHAN-1:0] i_chan_level,
    input wire logic                o_port0_data_avail_n,
    input wire logic                o_port1_data_avail_n,
    input wire logic                o_port2_data_avail_n,
    input wire logic                o_port3_data_avail_n,
    input wire logic                o_port0_event_irq_n,
    input wire logic                o_port1_event_irq_n,
    input wire logic                o_port2_event_irq_n,
    input wire logic                o_port3_event_irq_n,
    input wire logic                o_sysreset_n,
    input wire logic                o_sysreset_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en;
    int   cnt;
    int   stab;
    int   lim;
    wire logic kick = i_rd && i_addr == ADDR_WDT_STAT;
    wire logic ctl  = i_wr && i_addr == ADDR_CTRL;
    wire logic [3:0] dav_n = {o_port3_data_avail_n, o_port2_data_avail_n,
                              o_port1_data_avail_n, o_port0_data_avail_n};
    wire logic [3:0] irq_n = {o_port3_event_irq_n, o_port2_event_irq_n,
                              o_port1_event_irq_n, o_port0_event_irq_n};

    assign lim = (i_timeout_strap_a && !i_timeout_strap_b) ? 150 :
                 (!i_timeout_strap_a && !i_timeout_strap_b) ? 600 : 1200;

    // Cycles since the watchdog was last restarted
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            en   <= 1'b0;
            cnt  <= 0;
            stab <= 0;
        end
        else
        begin
            if (ctl)
                en <= i_wdata[CTRL_WDT_EN] && !i_wdata[CTRL_SOFT_RST];
            cnt  <= (kick || (ctl && !en)) ? 0 : cnt + 1;
            stab <= !$stable(i_chan_level) ? 0 : (stab < 8 ? stab + 1 : 8);
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_reset_oe_pair: assert property (o_sysreset_oe == !o_sysreset_n)
        else $error("system reset level and enable disagree");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 0)
        else $error("read data outside the answer cycle");
    a_irq_has_marker: assert property ((~irq_n & dav_n) == 4'h0)
        else $error("port interrupt without data marker");
    a_off_no_reset: assert property (!o_sysreset_n |->
        en || $past(en) || $past(en, 2))
        else $error("system reset while watchdog disabled");
    a_kick_release: assert property (kick |-> ##[1:3] o_sysreset_n)
        else $error("status read did not restart watchdog");
    a_expiry_early: assert property ($fell(o_sysreset_n) |->
        cnt >= (lim - 1) * WDT_TICK_CYC)
        else $error("watchdog expired too early");
    a_expiry_late: assert property (en &&
        cnt == (lim + 1) * WDT_TICK_CYC + 6 |-> !o_sysreset_n)
        else $error("watchdog failed to expire");
    a_pair_live: assert property (i_rd && i_addr == ADDR_PORT01 &&
        stab >= 3 |=> o_rdata == $past(i_chan_level[31:0]))
        else $error("paired port read not live level");
endmodule : iwd_props

bind iwd_top iwd_props #(.WDT_TICK_CYC(WDT_TICK_CYC)) i_props (.*);

`default_nettype wire

// ### verification/iwd_field_model.sv
// Field side: channel levels and per-port capture triggers.
// Assumes the bench calls its tasks from the module clock domain.
`default_nettype none

module iwd_field_model
    import iwd_pkg::*;
(
    input  wire logic                i_clk_sys,
    output var logic [NUM_CHAN-1:0]  o_chan_level,
    output var logic [NUM_PORTS-1:0] o_trig_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_chan_level = '0;
        o_trig_n     = '1;
    end
    task automatic set_level(input logic [NUM_CHAN-1:0] v);
        @(posedge i_clk_sys);
        o_chan_level <= v;
    endtask : set_level
    // Each trigger is pulsed on its own, apart from the others
    task automatic pulse(input int k);
        @(posedge i_clk_sys);
        o_trig_n[k] <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        o_trig_n[k] <= 1'b1;
    endtask : pulse
endmodule : iwd_field_model

`default_nettype wire

// ### verification/iwd_top_tb.sv
// Self-checking bench for the watchdog, port reads and markers.
// Assumes a four-cycle watchdog tick to keep timeouts short.
`default_nettype none

module iwd_top_tb
    import iwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [1:0]  strap = 2'h0;
    logic [31:0] rdata;
    logic [63:0] lvl;
    logic [3:0]  trig_n;
    logic [3:0]  dav_n;
    logic [3:0]  irq_n;
    logic        srst_n;
    logic        srst_oe;
    logic        irq;
    int          fail_count = 0;
    int          n_compared = 0;

    always #25 clk = ~clk;

    iwd_field_model i_fld (.i_clk_sys(clk), .o_chan_level(lvl),
        .o_trig_n(trig_n));
    iwd_top #(.WDT_TICK_CYC(T)) i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd),
        .o_rdata(rdata), .i_timeout_strap_a(strap[0]),
        .i_timeout_strap_b(strap[1]), .i_chan_level(lvl),
        .i_port0_capture_trigger_n(trig_n[0]),
        .i_port1_capture_trigger_n(trig_n[1]),
        .i_port2_capture_trigger_n(trig_n[2]),
        .i_port3_capture_trigger_n(trig_n[3]),
        .o_port0_data_avail_n(dav_n[0]), .o_port1_data_avail_n(dav_n[1]),
        .o_port2_data_avail_n(dav_n[2]), .o_port3_data_avail_n(dav_n[3]),
        .o_port0_event_irq_n(irq_n[0]), .o_port1_event_irq_n(irq_n[1]),
        .o_port2_event_irq_n(irq_n[2]), .o_port3_event_irq_n(irq_n[3]),
        .o_sysreset_n(srst_n), .o_sysreset_oe(srst_oe), .o_irq(irq));

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string s);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input string s);
        @(posedge clk);
        addr   <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk(rdata & m, e, s);
    endtask : rd_reg

    task automatic t_reset_states();
        for (int k = 0; k < 2; k++)
        begin
            rd_reg(ADDR_CTRL, '1, 32'h0, "ctrl");
            rd_reg(ADDR_WDT_STAT, 32'h3, 32'h0, "wdt off");
            rd_reg(ADDR_DEBOUNCE, 32'hFFFF, 32'h00B4, "debounce");
            rd_reg(ADDR_IRQ_EN, '1, 32'h0, "irq enables");
            wr_reg(ADDR_DEBOUNCE, 32'h0005);
            wr_reg(ADDR_IRQ_EN, 32'h00FF);
            rd_reg(ADDR_IRQ_EN, '1, 32'h00FF, "irq en back");
            wr_reg(ADDR_CTRL, 32'h0003);
            rd_reg(ADDR_CTRL, '1, 32'h3, "ctrl back");
            wr_reg(ADDR_CTRL, 32'h0004);
        end
        wr_reg(ADDR_WDT_STAT, 32'h0001);
        rd_reg(ADDR_WDT_STAT, 32'h1, 32'h0, "read only");
        rd_reg(8'h3C, '1, 32'h0, "unmapped");
        $display("Test reset states done");
    endtask : t_reset_states

    task automatic t_ports();
        logic [63:0] v;
        v = 64'hF00D_5A5A_0FF0_C3A5;
        i_fld.set_level(v);
        repeat (4) @(posedge clk);
        for (int p = 0; p < 4; p++)
            rd_reg(ADDR_PORT0 + 8'(4 * p), '1, {16'h0, v[16*p +: 16]},
                   "port word");
        rd_reg(ADDR_PORT01, '1, v[31:0], "ports 0 and 1");
        rd_reg(ADDR_PORT23, '1, v[63:32], "ports 2 and 3");
        $display("Test ports done");
    endtask : t_ports

    task automatic t_wdt(input logic [1:0] code, input int lim);
        int n;
        wr_reg(ADDR_CTRL, 32'h0);
        strap <= code;
        repeat (4) @(posedge clk);
        wr_reg(ADDR_MASK, 32'h1);
        wr_reg(ADDR_CTRL, 32'h1);
        repeat (2)
        begin
            repeat (lim * T / 2) @(posedge clk);
            rd_reg(ADDR_WDT_STAT, 32'h1, 32'h1, "enabled");
        end
        chk(srst_n, 1'b1, "kept alive");
        n = 0;
        while (srst_n === 1'b1 && n < 2 * lim * T)
        begin
            @(posedge clk);
            n++;
        end
        chk(n >= (lim - 1) * T && n <= (lim + 1) * T + 6, 1, "timeout");
        if (n >= 2 * lim * T)
            summarize();
        chk(srst_oe, 1'b1, "reset driven");
        repeat (8) @(posedge clk);
        chk(irq, 1'b1, "irq raised");
        rd_reg(ADDR_WDT_STAT, 32'h3, 32'h3, "expired flag");
        repeat (3) @(posedge clk);
        chk(srst_n, 1'b1, "released");
        wr_reg(ADDR_CTRL, 32'h0);
        wr_reg(ADDR_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
        $display("Test watchdog straps %b done", code);
    endtask : t_wdt

    task automatic t_markers();
        logic [3:0] hot_n;
        wr_reg(ADDR_MASK, 32'h0);
        wr_reg(ADDR_CTRL, 32'h2);
        wr_reg(ADDR_IRQ_EN, 32'hF);
        for (int p = 0; p < 4; p++)
        begin
            i_fld.pulse(p);
            hot_n = ~(4'h1 << p);
            repeat (4) @(posedge clk);
            chk(dav_n, hot_n, "marker");
            chk(irq_n, hot_n, "port irq");
            rd_reg(ADDR_PORT0 + 8'(4 * p), '1,
                   {16'h0, lvl[16*p +: 16]}, "clear");
            repeat (2) @(posedge clk);
            chk(dav_n, 4'hF, "read clears");
        end
        chk(irq, 1'b0, "masked");
        wr_reg(ADDR_MASK, 32'h1E);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1, "unmasked");
        wr_reg(ADDR_MASK, 32'h0);
        wr_reg(ADDR_CTRL, 32'h0);
        repeat (25) @(posedge clk);
        chk(dav_n, 4'h0, "internal sample");
        wr_reg(ADDR_IRQ_EN, 32'h0);
        wr_reg(ADDR_STATUS, 32'h1E);
        $display("Test markers done");
    endtask : t_markers

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_states();
        t_ports();
        t_wdt(2'h0, 600);
        t_wdt(2'h1, 150);
        t_wdt(2'h2, 1200);
        t_wdt(2'h3, 1200);
        t_markers();
        repeat (1300 * T) @(posedge clk);
        chk(srst_n, 1'b1, "disabled stays quiet");
        summarize();
    end
endmodule : iwd_top_tb

`default_nettype wire
